// ---- core/rsq_pkg.sv ----
// Shared constants for the reset sequencer and its watchdog counter.
package rsq_pkg;

	// System clock period and derived timing.
	localparam int SYS_CLK_NS            = 40;
	localparam int STARTUP_TOUT0_NS      = 1_000;
	localparam int STARTUP_TOUT1_NS      = 4_100_000;
	localparam int STARTUP_TOUT2_NS      = 65_000_000;
	localparam int STARTUP_TOUT3_NS      = 16_000;
	localparam int STARTUP_TOUT0_CYC     = (STARTUP_TOUT0_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int STARTUP_TOUT1_CYC     = (STARTUP_TOUT1_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int STARTUP_TOUT2_CYC     = (STARTUP_TOUT2_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int STARTUP_TOUT3_CYC     = (STARTUP_TOUT3_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int BROWNOUT_FILTER_NS    = 2_000;
	localparam int BROWNOUT_FILTER_CYC   = (BROWNOUT_FILTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int TURNOFF_WINDOW_CYC    = 4;
	localparam int WDOG_BASE_TICKS_DEF   = 16_384;

	// Counter widths.
	localparam int DELAY_CNT_W           = 24;
	localparam int WDOG_CNT_W            = 22;
	localparam int FILT_CNT_W            = 8;

	// Register offsets.
	localparam logic [3:0] ADDR_FLAGS     = 4'h0;
	localparam logic [3:0] ADDR_WDOG_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS    = 4'h2;

	// Reset flag positions.
	localparam int FLAG_POWERON          = 0;
	localparam int FLAG_EXTERNAL         = 1;
	localparam int FLAG_BROWNOUT         = 2;
	localparam int FLAG_WATCHDOG         = 3;
	localparam int FLAG_TESTPORT         = 4;
	localparam int FLAGS_W               = 5;

	// Watchdog control field positions.
	localparam int WDOG_TURNOFF_BIT      = 4;
	localparam int WDOG_ENABLE_BIT       = 3;
	localparam int WDOG_PERIOD_LSB       = 0;
	localparam int WDOG_PERIOD_W         = 3;

	// Reset values.
	localparam logic [FLAGS_W-1:0]       FLAGS_RST       = 5'h00;
	localparam logic [WDOG_PERIOD_W-1:0] WDOG_PERIOD_RST = 3'h0;

endpackage : rsq_pkg

// ---- core/rsq_wdog_counter.sv ----
// Watchdog time-out counter fed by ticks of the watchdog oscillator.
`timescale 1ns/100ps
`default_nettype none

module rsq_wdog_counter
	import rsq_pkg::*;
#(
	parameter int BASE_TICKS = WDOG_BASE_TICKS_DEF   // Shortest period in oscillator ticks.
) (
	input  wire logic                     i_mclk,     // System clock.
	input  wire logic                     i_rst_n,    // Synchronous reset, active low.
	input  wire logic                     i_tick,     // One pulse per oscillator period.
	input  wire logic                     i_enable,   // Watchdog enabled.
	input  wire logic                     i_clear,    // Restart or chip reset.
	input  wire logic [WDOG_PERIOD_W-1:0] i_period,   // Period select.
	output logic                          o_timeout   // One-cycle expiry pulse.
);

	logic [WDOG_CNT_W-1:0] count;
	logic [WDOG_CNT_W-1:0] limit;

	// Each step of the select doubles the period.
	// period doubling per step
	function automatic logic [WDOG_CNT_W-1:0] period_ticks(input logic [WDOG_PERIOD_W-1:0] sel);
		period_ticks = WDOG_CNT_W'(BASE_TICKS) << sel;
	endfunction : period_ticks

	assign limit = period_ticks(i_period);

	// Count oscillator ticks; a disabled or cleared watchdog holds at zero.
	// counter clear conditions
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || i_clear || !i_enable) begin
			count     <= '0;
			o_timeout <= 1'b0;
		end else if (i_tick && count == limit - 1'b1) begin
			count     <= '0;
			o_timeout <= 1'b1;
		end else begin
			count     <= i_tick ? count + 1'b1 : count;
			o_timeout <= 1'b0;
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	timeout_enabled_a: assert property (o_timeout |-> $past(i_enable) && !$past(i_clear))
		else $error("Watchdog expired while disabled or cleared.");
	clear_zero_a: assert property (i_clear |=> count == '0 && !o_timeout)
		else $error("Watchdog counter not cleared.");
	period_end_a: assert property (o_timeout |-> $past(count) == $past(limit) - 1'b1 && $past(i_tick))
		else $error("Watchdog expired at the wrong count.");
	pulse_width_a: assert property (o_timeout |=> !o_timeout)
		else $error("Watchdog pulse longer than one cycle.");

endmodule : rsq_wdog_counter

`default_nettype wire

// ---- core/rsq_reset_seq.sv ----
// Reset sequencer: merges reset sources, stretches reset, keeps flags and watchdog control.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Reset initialises registers, then vector fetch.
// - Ports reset asynchronously on any source; brownout and watchdog reach them only through clocked logic.
// - Delay counter stretches reset, length from fuses.
// - Five sources: poweron, pin, watchdog, brownout, testport.
// - Testport reset holds while its bit is one.
// - Poweron low resets; rising starts delay.
// - Pin pulses longer than minimum reset device.
// - Pin release starts delay before operation.
// - Enabled brownout resets, release after delay.
// - Brownout ignores dips shorter than filter.
// - Watchdog resets only while enabled.
// - Watchdog pulse one cycle, delay after.
// - Bandgap on for brownout, comparator, converter.
// - Watchdog counts its own oscillator.
// - Watchdog clears on restart, disable, reset.
// - Eight periods; expiry restarts at vector.
// - Plain writes cannot clear watchdog enable.
// - Turn-off window lasts four cycles.
// - Periods double from 16K to 2048K.
// - Sources set flags; poweron clears others.

module rsq_reset_seq
	import rsq_pkg::*;
#(
	parameter int TOUT0_CYC       = STARTUP_TOUT0_CYC,    // Start-up delay, fuse code 0.
	parameter int TOUT1_CYC       = STARTUP_TOUT1_CYC,    // Start-up delay, fuse code 1.
	parameter int TOUT2_CYC       = STARTUP_TOUT2_CYC,    // Start-up delay, fuse code 2.
	parameter int TOUT3_CYC       = STARTUP_TOUT3_CYC,    // Start-up delay, fuse code 3.
	parameter int WDOG_BASE_TICKS = WDOG_BASE_TICKS_DEF   // Shortest watchdog period in ticks.
) (
	input  wire logic       i_mclk,                       // System clock, 25 MHz.
	input  wire logic       i_rst_n,                      // Synchronous reset, active low.
	input  wire logic       i_supply_below_por,           // Power-on comparator, high when low.
	input  wire logic       i_reset_pin_n,                // External reset pin, active low.
	input  wire logic       i_supply_below_bot,           // Brown-out comparator, high when low.
	input  wire logic       i_testport_reset,             // Test-chain reset register bit.
	input  wire logic       i_wdog_osc,                   // Watchdog oscillator, about 1 MHz.
	input  wire logic       i_brownout_enable_fuse,       // Brown-out detector enabled.
	input  wire logic [1:0] i_clock_select_fuses,         // Start-up delay select.
	input  wire logic       i_comparator_bandgap_select,  // Comparator uses the bandgap.
	input  wire logic       i_converter_enable,           // Converter enabled.
	input  wire logic       i_watchdog_restart_instr,     // Watchdog restart pulse.
	input  wire logic [3:0] i_addr,                       // Register address.
	input  wire logic [7:0] i_wdata,                      // Register write data.
	input  wire logic       i_wr,                         // Write strobe.
	input  wire logic       i_rd,                         // Read strobe.
	output logic      [7:0] o_rdata,                      // Read data, cycle after strobe.
	output logic            o_sys_reset,                  // Chip-wide internal reset.
	output logic            o_io_reset_n,                 // Port reset, active low, no clock needed.
	output logic            o_vector_fetch,               // Pulse: start at reset vector.
	output logic            o_bandgap_en                  // Bandgap reference enable.
);

	// Synchroniser stages for pins from outside the clock domain.
	logic                     por_s1, por_s2;
	logic                     pin_s1, pin_s2;
	logic                     bot_s1, bot_s2;
	logic                     tp_s1, tp_s2;
	logic                     osc_s1, osc_s2, osc_s3;
	logic                     wdog_tick;

	// Brown-out filter state.
	logic [FILT_CNT_W-1:0]    bod_cnt;
	logic                     bod_active;

	// Reset merging and stretching.
	logic                     src_any;
	logic                     next_sys_reset;
	logic [DELAY_CNT_W-1:0]   delay_cnt;

	// Software-visible state.
	logic [FLAGS_W-1:0]       flags;
	logic                     wdog_en;
	logic                     turnoff_en;
	logic [1:0]               turnoff_cnt;
	logic [WDOG_PERIOD_W-1:0] wdog_period;
	logic                     wdog_pulse;
	logic                     wr_ctrl;
	logic                     wr_flags;

	// Start-up delay in system clock cycles for a fuse code.
	function automatic logic [DELAY_CNT_W-1:0] tout_cycles(input logic [1:0] sel);
		if (sel == 2'h0) begin
			tout_cycles = DELAY_CNT_W'(TOUT0_CYC);
		end else if (sel == 2'h1) begin
			tout_cycles = DELAY_CNT_W'(TOUT1_CYC);
		end else if (sel == 2'h2) begin
			tout_cycles = DELAY_CNT_W'(TOUT2_CYC);
		end else begin
			tout_cycles = DELAY_CNT_W'(TOUT3_CYC);
		end
	endfunction : tout_cycles

	// Two flip-flops on each supply, pin and test input before the clocked logic reads it.
	// Power-on and pin stages reset to their active level, so no source is lost at release.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			por_s1 <= 1'b1;
			por_s2 <= 1'b1;
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			bot_s1 <= 1'b0;
			bot_s2 <= 1'b0;
			tp_s1  <= 1'b0;
			tp_s2  <= 1'b0;
		end else begin
			por_s1 <= i_supply_below_por;
			por_s2 <= por_s1;
			pin_s1 <= i_reset_pin_n;
			pin_s2 <= pin_s1;
			bot_s1 <= i_supply_below_bot;
			bot_s2 <= bot_s1;
			tp_s1  <= i_testport_reset;
			tp_s2  <= tp_s1;
		end
	end

	// The watchdog oscillator is sampled and its rising edges become ticks.
	// separate oscillator ticks
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
		end else begin
			osc_s1 <= i_wdog_osc;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
		end
	end

	// Edge detect reads only the second and third stages.
	assign wdog_tick = osc_s2 && !osc_s3;

	// A low supply must persist for the filter time before it counts.
	// Recovery releases at once; the delay counter then does the stretching.
	// A dip shorter than the filter never reaches the merge, so it sets no flag.
	// brown-out glitch filter
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || !i_brownout_enable_fuse || !bot_s2) begin
			bod_cnt    <= '0;
			bod_active <= 1'b0;
		end else if (bod_cnt == FILT_CNT_W'(BROWNOUT_FILTER_CYC - 1)) begin
			bod_active <= 1'b1;
		end else begin
			bod_cnt    <= bod_cnt + 1'b1;
		end
	end

	// Any live source holds reset; a pin pulse only counts once sampled.
	// five reset sources
	assign src_any = por_s2 || !pin_s2 || bod_active || tp_s2 || wdog_pulse;

	// Reset stays high while a source is live or the delay is still running.
	// merged reset term
	assign next_sys_reset = src_any || (delay_cnt != '0);

	// The delay reloads while any source is active, so every release restarts it.
	// The counter is sized for the longest fuse code at the default clock.
	// start-up delay counter
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			delay_cnt <= tout_cycles(2'h0);
		end else if (src_any) begin
			delay_cnt <= tout_cycles(i_clock_select_fuses);
		end else if (delay_cnt != '0) begin
			delay_cnt <= delay_cnt - 1'b1;
		end
	end

	// Registered release keeps the falling edge glitch free and synchronous.
	// synchronous release
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_sys_reset    <= 1'b1;
			o_vector_fetch <= 1'b0;
		end else begin
			o_sys_reset    <= next_sys_reset;
			o_vector_fetch <= o_sys_reset && !next_sys_reset;
		end
	end

	// Port reset uses the raw pins so it acts even with the clock stopped.
	// Raw brown-out is left out because it has no filter without a clock.
	// asynchronous port reset
	// raw pin acts without a clock
	assign o_io_reset_n = !(i_supply_below_por || !i_reset_pin_n || i_testport_reset
		|| bod_active || wdog_pulse || o_sys_reset);

	// Bandgap is requested by any of its three users.
	// bandgap enable
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_bandgap_en <= 1'b0;
		end else begin
			o_bandgap_en <= i_brownout_enable_fuse || i_comparator_bandgap_select || i_converter_enable;
		end
	end

	// Register writes: control is locked while the chip is held in reset.
	// Flag writes are taken at any time except during power-on, since they can only ever clear bits.
	assign wr_ctrl  = i_wr && (i_addr == ADDR_WDOG_CTRL) && !o_sys_reset;
	assign wr_flags = i_wr && (i_addr == ADDR_FLAGS);

	// Reset flags: a set in the same cycle as a clear wins.
	// reset cause flags
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			flags <= FLAGS_RST;
		end else if (por_s2) begin
			flags                <= '0;
			flags[FLAG_POWERON]  <= 1'b1;
		end else begin
			flags <= (wr_flags ? (flags & i_wdata[FLAGS_W-1:0]) : flags)
				| ((FLAGS_W'(!pin_s2)      << FLAG_EXTERNAL)
				|  (FLAGS_W'(bod_active)   << FLAG_BROWNOUT)
				|  (FLAGS_W'(wdog_pulse)   << FLAG_WATCHDOG)
				|  (FLAGS_W'(tp_s2)        << FLAG_TESTPORT));
		end
	end

	// Watchdog enable and period; a chip reset returns them to defaults.
	// protected enable clear
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || o_sys_reset) begin
			wdog_en     <= 1'b0;
			wdog_period <= WDOG_PERIOD_RST;
		end else if (wr_ctrl) begin
			wdog_period <= i_wdata[WDOG_PERIOD_LSB +: WDOG_PERIOD_W];
			if (i_wdata[WDOG_ENABLE_BIT]) begin
				wdog_en <= 1'b1;
			end else if (turnoff_en) begin
				wdog_en <= 1'b0;
			end
		end
	end

	// Turn-off window opens on a write of both bits and closes by itself.
	// A rewrite of both bits inside the window simply reloads it.
	// four-cycle turn-off window
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || o_sys_reset) begin
			turnoff_en  <= 1'b0;
			turnoff_cnt <= '0;
		end else if (wr_ctrl && i_wdata[WDOG_TURNOFF_BIT] && i_wdata[WDOG_ENABLE_BIT]) begin
			turnoff_en  <= 1'b1;
			turnoff_cnt <= 2'(TURNOFF_WINDOW_CYC - 1);
		end else if (turnoff_cnt != '0) begin
			turnoff_cnt <= turnoff_cnt - 1'b1;
		end else begin
			turnoff_en  <= 1'b0;
		end
	end

	// Watchdog counter; chip reset and restart both clear it.
	// eight periods, expiry resets
	rsq_wdog_counter #(
		.BASE_TICKS (WDOG_BASE_TICKS)
	) u_wdog (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_tick    (wdog_tick),
		.i_enable  (wdog_en),
		.i_clear   (i_watchdog_restart_instr || o_sys_reset),
		.i_period  (wdog_period),
		.o_timeout (wdog_pulse)
	);

	// Read data stand for exactly one cycle; unmapped addresses read zero.
	// Driving zero outside the read cycle lets several such ports be ORed together.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || !i_rd) begin
			o_rdata <= 8'h00;
		end else if (i_addr == ADDR_FLAGS) begin
			o_rdata <= 8'(flags);
		end else if (i_addr == ADDR_WDOG_CTRL) begin
			o_rdata <= 8'({turnoff_en, wdog_en, wdog_period});
		end else if (i_addr == ADDR_STATUS) begin
			o_rdata <= {6'h00, bod_active, o_bandgap_en};
		end else begin
			o_rdata <= 8'h00;
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	source_holds_a: assert property (src_any |=> o_sys_reset && delay_cnt == $past(tout_cycles(i_clock_select_fuses)))
		else $error("Live source did not hold reset with a fresh delay.");
	delay_count_a: assert property (!src_any && delay_cnt != '0 |=> o_sys_reset && delay_cnt == $past(delay_cnt) - 1'b1)
		else $error("Delay counter did not stretch reset.");
	por_flag_a: assert property (por_s2 |=> o_sys_reset && flags == (FLAGS_W'(1) << FLAG_POWERON))
		else $error("Power-on did not reset and clear other flags.");
	testport_hold_a: assert property (tp_s2 [*2] |=> o_sys_reset && flags[FLAG_TESTPORT])
		else $error("Testport reset did not hold reset.");
	bod_filter_a: assert property ($rose(bod_active) |-> $past(bot_s2, 1) && $past(bot_s2, 2) && i_brownout_enable_fuse)
		else $error("Brown-out fired without a sustained low supply.");
	wdog_reset_a: assert property (wdog_pulse |=> o_sys_reset && !wdog_pulse && flags[FLAG_WATCHDOG])
		else $error("Watchdog pulse did not reset and flag.");
	turnoff_len_a: assert property ($rose(turnoff_en) |-> turnoff_en [*4])
		else $error("Turn-off window shorter than four cycles.");
	turnoff_close_a: assert property (turnoff_en && turnoff_cnt == '0 && !wr_ctrl |=> !turnoff_en)
		else $error("Turn-off window did not close.");
	enable_kept_a: assert property (wdog_en && wr_ctrl && !turnoff_en && !o_sys_reset |=> wdog_en)
		else $error("Plain write cleared the watchdog enable.");
	bandgap_on_a: assert property (i_brownout_enable_fuse || i_comparator_bandgap_select || i_converter_enable
		|=> o_bandgap_en)
		else $error("Bandgap not enabled for a user.");
	release_vector_a: assert property ($fell(o_sys_reset) |-> o_vector_fetch && $past(delay_cnt) == '0)
		else $error("Reset released without vector fetch or early.");
	io_reset_a: assert property (o_sys_reset |-> !o_io_reset_n)
		else $error("Ports not held in reset.");

	// Further checks on release, brown-out gating, flags, watchdog control and the bandgap.
	vector_pulse_a: assert property (o_vector_fetch |=> !o_vector_fetch)
		else $error("Vector fetch pulse longer than one cycle.");
	bod_gate_a: assert property (!i_brownout_enable_fuse |=> !bod_active)
		else $error("Brown-out active with its fuse clear.");
	flag_clear_a: assert property (wr_flags && !por_s2 && !i_wdata[FLAG_POWERON]
		|=> !flags[FLAG_POWERON])
		else $error("Written zero did not clear the power-on flag.");
	ctrl_reset_a: assert property (o_sys_reset |=> !wdog_en && !turnoff_en)
		else $error("Chip reset left the watchdog enabled.");
	enable_set_a: assert property (wr_ctrl && i_wdata[WDOG_ENABLE_BIT] |=> wdog_en)
		else $error("Write of one did not enable the watchdog.");
	disable_ok_a: assert property (wr_ctrl && turnoff_en && !i_wdata[WDOG_ENABLE_BIT] |=> !wdog_en)
		else $error("Protected disable did not clear the enable.");
	bandgap_off_a: assert property (!i_brownout_enable_fuse && !i_comparator_bandgap_select && !i_converter_enable
		|=> !o_bandgap_en)
		else $error("Bandgap left on with no user.");

endmodule : rsq_reset_seq

`default_nettype wire

// ---- testbench/rsq_partner.sv ----
// Behavioural far side: supply comparators, external reset pin and watchdog oscillator.
`timescale 1ns/100ps
`default_nettype none

module rsq_partner #(
	parameter int PIN_MIN_CYC = 3,    // Shortest pin pulse, in clocks.
	parameter int OSC_HALF_NS = 500   // Half period of the 1 MHz oscillator.
) (
	input  wire logic i_mclk,             // System clock.
	input  wire logic i_por_low,          // Bench: supply under power-on level.
	input  wire logic i_pin_low,          // Bench: pin reset wanted.
	input  wire logic i_bot_low,          // Bench: supply under brown-out level.
	output logic      o_supply_below_por, // Power-on comparator.
	output logic      o_reset_pin_n,      // External reset pin.
	output logic      o_supply_below_bot, // Brown-out comparator.
	output logic      o_wdog_osc          // Watchdog oscillator.
);
	int pin_cnt;

	// The comparators follow the supply a clock late, like a slow analog edge.
	always @(posedge i_mclk) begin
		o_supply_below_por <= i_por_low;
		o_supply_below_bot <= i_bot_low;
	end

	// pin pulse width
	// A short request is stretched, since shorter pulses need not reset the device.
	always @(posedge i_mclk) begin
		if (i_pin_low)
			pin_cnt <= PIN_MIN_CYC;
		else if (pin_cnt > 0)
			pin_cnt <= pin_cnt - 1;
		o_reset_pin_n <= !(i_pin_low || pin_cnt > 1);
	end

	// separate oscillator
	// Free running and out of phase with the system clock on purpose.
	initial begin
		o_wdog_osc = 1'b0;
		#7;
		forever #(OSC_HALF_NS) o_wdog_osc = ~o_wdog_osc;
	end
endmodule : rsq_partner

`default_nettype wire

// ---- testbench/rsq_reset_seq_tb_top.sv ----
// Self-checking bench for the reset sequencer and its watchdog.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("MISMATCH %0t got %h expected %h", $time, got, exp); end end

module rsq_reset_seq_tb_top
	import rsq_pkg::*;
;
	localparam int TOUT_CYC [4] = '{6, 20, 34, 48};
	localparam int OSC_CYC      = 25;
	localparam int WD_TICKS     = 4;
	// Rows: brown-out fuse, comparator select, converter enable, expected reference enable.
	localparam logic [3:0] BG_ROWS [8] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};

	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       por_low = 1'b1;
	logic       pin_low = 1'b0;
	logic       bot_low = 1'b0;
	logic       testport = 1'b0;
	logic       bod_fuse = 1'b0;
	logic [1:0] clock_select_fuses = 2'h0;
	logic       comparator_bandgap_select = 1'b0;
	logic       conv = 1'b0;
	logic       watchdog_restart_instr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	wire logic  below_por, pin_n, below_bot, wdog_osc;
	wire logic  sys_reset, io_reset_n, vector_fetch, bandgap_en;
	wire logic [7:0] rdata;
	int         failures = 0;
	int         comparisons = 0;
	int         n;

	// Clock at 25 MHz.
	initial forever #20 mclk = ~mclk;

	rsq_partner rsq_partner_i (.i_mclk(mclk), .i_por_low(por_low), .i_pin_low(pin_low), .i_bot_low(bot_low),
		.o_supply_below_por(below_por), .o_reset_pin_n(pin_n), .o_supply_below_bot(below_bot),
		.o_wdog_osc(wdog_osc));

	// Short delays and watchdog base keep the run brief; expectations derive from them.
	rsq_reset_seq #(.TOUT0_CYC(TOUT_CYC[0]), .TOUT1_CYC(TOUT_CYC[1]), .TOUT2_CYC(TOUT_CYC[2]),
		.TOUT3_CYC(TOUT_CYC[3]), .WDOG_BASE_TICKS(WD_TICKS)) rsq_reset_seq_i (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_supply_below_por(below_por), .i_reset_pin_n(pin_n),
		.i_supply_below_bot(below_bot), .i_testport_reset(testport), .i_wdog_osc(wdog_osc),
		.i_brownout_enable_fuse(bod_fuse), .i_clock_select_fuses(clock_select_fuses), .i_comparator_bandgap_select(comparator_bandgap_select),
		.i_converter_enable(conv), .i_watchdog_restart_instr(watchdog_restart_instr), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_sys_reset(sys_reset), .o_io_reset_n(io_reset_n),
		.o_vector_fetch(vector_fetch), .o_bandgap_en(bandgap_en));

	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// Leaves each wait 1 ns past the edge so registered outputs have settled.
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		tick(0);
	endtask : bus_wr

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		tick(0);
		`CHK(rdata & mask, exp) // Tagged at each caller.
	endtask : chk_rd

	// Bounded wait for the internal reset level; running out ends the run.
	task automatic wait_sys(input logic val, input int bound, output int k);
		k = 0;
		while (sys_reset !== val) begin
			if (k == bound) begin
				failures++;
				$display("MISMATCH %0t internal reset level not reached", $time);
				complete_run();
			end
			tick(1);
			k++;
		end
	endtask : wait_sys

	// Counts cycles in which the internal reset leaves the level it must hold.
	task automatic hold(input int k, input logic lvl);
		int bad;
		bad = 0;
		repeat (k) begin
			tick(1);
			if (sys_reset !== lvl)
				bad++;
		end
		`CHK(bad, 0) // Tagged at each caller.
	endtask : hold

	// Release delay must match the selected code, then one vector-fetch pulse.
	task automatic measure(input int c);
		int k;
		int vf;
		wait_sys(1'b0, 300, k);
		`CHK(k >= TOUT_CYC[c] && k <= TOUT_CYC[c] + 10, 1'b1) // Delay length.
		vf = int'(vector_fetch === 1'b1);
		repeat (2) begin
			tick(1);
			vf += int'(vector_fetch === 1'b1);
		end
		`CHK(vf, 1) // Single vector fetch.
	endtask : measure

	initial begin
		tick(7);
		`CHK(sys_reset, 1'b1) // Reset during bench reset.
		`CHK(io_reset_n, 1'b0) // Ports held.
		`CHK(rdata, 8'h00) // Initial read data.
		@(posedge mclk) rst_n <= 1'b1;
		tick(10);
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h01); // Power-on flag only.
		@(posedge mclk) por_low <= 1'b0;
		measure(0); // Supply rise starts delay.
		foreach (BG_ROWS[r]) begin
			@(posedge mclk) {bod_fuse, comparator_bandgap_select, conv} <= BG_ROWS[r][3:1];
			tick(3);
			`CHK(bandgap_en, BG_ROWS[r][0]) // Reference enable.
		end
		chk_rd(ADDR_STATUS, 8'h01, 8'h01); // Status shows reference.
		@(posedge mclk) {comparator_bandgap_select, conv} <= 2'h0;
		for (int c = 0; c < 4; c++) begin
			@(posedge mclk) clock_select_fuses <= 2'(c);
			@(posedge mclk) pin_low <= 1'b1;
			tick(2);
			`CHK(io_reset_n, 1'b0) // Ports follow pin at once.
			tick(4);
			`CHK(sys_reset, 1'b1) // Pin pulse resets.
			@(posedge mclk) pin_low <= 1'b0;
			measure(c); // Pin release starts delay.
		end
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h03); // External flag set.
		bus_wr(ADDR_FLAGS, 8'h01);
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h01); // Zero clears, one keeps.
		@(posedge mclk) clock_select_fuses <= 2'h0;
		@(posedge mclk) bot_low <= 1'b1;
		hold(BROWNOUT_FILTER_CYC - 10, 1'b0); // Short dip ignored.
		@(posedge mclk) bot_low <= 1'b0;
		hold(10, 1'b0); // Still running.
		@(posedge mclk) bot_low <= 1'b1;
		wait_sys(1'b1, BROWNOUT_FILTER_CYC + 10, n);
		`CHK(n >= BROWNOUT_FILTER_CYC, 1'b1) // Filter time honoured.
		tick(20);
		@(posedge mclk) bot_low <= 1'b0;
		measure(0); // Recovery waits the delay.
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h05); // Brown-out flag set.
		@(posedge mclk) bod_fuse <= 1'b0;
		@(posedge mclk) bot_low <= 1'b1;
		hold(BROWNOUT_FILTER_CYC + 20, 1'b0); // Detector off when fuse clear.
		@(posedge mclk) bot_low <= 1'b0;
		@(posedge mclk) testport <= 1'b1;
		tick(6);
		hold(30, 1'b1); // Held while bit is one.
		@(posedge mclk) testport <= 1'b0;
		measure(0); // Delay after test release.
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h15); // Test flag set.
		for (int p = 0; p < 3; p++) begin
			bus_wr(ADDR_WDOG_CTRL, 8'h08 | 8'(p));
			wait_sys(1'b1, 500, n);
			// The first oscillator period after enabling may be partial.
			n -= (WD_TICKS << p) * OSC_CYC;
			`CHK(n >= -OSC_CYC && n <= 35, 1'b1) // Period.
			measure(0); // Delay after watchdog pulse.
			chk_rd(ADDR_WDOG_CTRL, 8'hFF, 8'h00); // Control cleared by chip reset.
		end
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h1D); // Watchdog flag set.
		bus_wr(ADDR_WDOG_CTRL, 8'h08);
		repeat (8) begin
			hold(60, 1'b0); // Restart keeps it quiet.
			@(posedge mclk) watchdog_restart_instr <= 1'b1;
			@(posedge mclk) watchdog_restart_instr <= 1'b0;
		end
		bus_wr(ADDR_WDOG_CTRL, 8'h00);
		chk_rd(ADDR_WDOG_CTRL, 8'h08, 8'h08); // Plain clear refused.
		bus_wr(ADDR_WDOG_CTRL, 8'h18);
		bus_wr(ADDR_WDOG_CTRL, 8'h00);
		chk_rd(ADDR_WDOG_CTRL, 8'h08, 8'h00); // Protected disable.
		hold(300, 1'b0); // Disabled watchdog stays quiet.
		bus_wr(ADDR_WDOG_CTRL, 8'h1F);
		chk_rd(ADDR_WDOG_CTRL, 8'hFF, 8'h1F); // Window open.
		tick(4);
		chk_rd(ADDR_WDOG_CTRL, 8'hFF, 8'h0F); // Window closed by hardware.
		bus_wr(ADDR_WDOG_CTRL, 8'h07);
		chk_rd(ADDR_WDOG_CTRL, 8'h08, 8'h08); // Late clear refused.
		bus_wr(ADDR_WDOG_CTRL, 8'h1F);
		bus_wr(ADDR_WDOG_CTRL, 8'h07);
		chk_rd(4'hF, 8'hFF, 8'h00); // Unmapped reads zero.
		@(posedge mclk) por_low <= 1'b1;
		tick(2);
		`CHK(io_reset_n, 1'b0) // Supply drop resets at once.
		tick(6);
		@(posedge mclk) por_low <= 1'b0;
		measure(0); // Delay after supply rise.
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h01); // Power-on clears other flags.
		bus_wr(ADDR_FLAGS, 8'h00);
		chk_rd(ADDR_FLAGS, 8'hFF, 8'h00); // Power-on flag cleared by zero.
		complete_run();
	end
endmodule : rsq_reset_seq_tb_top

`default_nettype wire
